/* File: hdl/can_tx_pkg.sv */
// shared constants and types of the transmit request and cancel block
package can_tx_pkg;

	// ==========================================================
	// widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned MBOX_W = 5;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned IRQ_W = 3;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] ADDR_TX_REQUEST = 8'h00;
	localparam logic [7:0] ADDR_TX_CANCEL = 8'h04;
	localparam logic [7:0] ADDR_SENT_ACK = 8'h08;
	localparam logic [7:0] ADDR_ABORT_ACK = 8'h0c;
	localparam logic [7:0] ADDR_TX_CONFIG = 8'h10;
	localparam logic [7:0] ADDR_NO_RETX = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

	// ==========================================================
	// fields and reset values
	localparam logic [31:0] MBOX_VALID_MASK = 32'hffff_fffe;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
	localparam logic [31:0] ONE_HOT_BASE = 32'h0000_0001;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam int unsigned IRQ_SENT_BIT = 0;
	localparam int unsigned IRQ_ABORT_BIT = 1;
	localparam int unsigned IRQ_DROP_BIT = 2;
	localparam logic [4:0] MBOX_NONE = 5'h00;

	// ==========================================================
	// types
	typedef struct packed {
		logic valid;
		logic [4:0] mbox;
	} tx_event_t;

	typedef enum logic [0:0] {
		bus_idle,
		bus_ack
	} bus_state_t;

endpackage

/* File: hdl/tx_mailbox_picker.sv */
// picks the lowest numbered mailbox that may start next
`timescale 1ns/10ps
`default_nettype none
module tx_mailbox_picker (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// candidates
	input wire logic [31:0] eligible_i,
	// choice
	output logic valid_o,
	output logic [4:0] mbox_o
);

	// ==========================================================
	// priority search
	logic next_valid;
	logic [4:0] next_mbox;

	always_comb begin
		next_valid = 1'b0;
		next_mbox = can_tx_pkg::MBOX_NONE;
		for (int i = 31; i >= 1; i--) begin
			if (eligible_i[i]) begin
				next_valid = 1'b1;
				next_mbox = i[4:0];
			end
		end
	end

	// ==========================================================
	// registered choice
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			mbox_o <= can_tx_pkg::MBOX_NONE;
		end else if (ce_i) begin
			valid_o <= next_valid;
			mbox_o <= next_mbox;
		end
	end

endmodule
`default_nettype wire

/* File: hdl/can_tx_request_cancel.sv */
// transmit request and cancel control for 31 transmit mailboxes
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module can_tx_request_cancel (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// frame engine events
	input wire can_tx_pkg::tx_event_t start_i,
	input wire can_tx_pkg::tx_event_t done_i,
	input wire can_tx_pkg::tx_event_t fail_i,
	// to frame engine
	output logic [31:0] tx_request_o,
	output logic [31:0] tx_cancel_o,
	output logic [31:0] no_auto_retransmit_o,
	output logic next_valid_o,
	output logic [4:0] next_mbox_o,
	// interrupt
	output logic irq_o
);

	// ==========================================================
	// decoding helpers
	function automatic logic [31:0] byte_mask(input logic [3:0] sel);
		byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [31:0] one_hot(input can_tx_pkg::tx_event_t ev);
		if (ev.valid)
			one_hot = (can_tx_pkg::ONE_HOT_BASE << ev.mbox) & can_tx_pkg::MBOX_VALID_MASK;
		else
			one_hot = can_tx_pkg::REG_RESET;
	endfunction

	// ==========================================================
	// state
	can_tx_pkg::bus_state_t state;
	logic [31:0] tx_request;
	logic [31:0] tx_cancel;
	logic [31:0] in_flight;
	logic [31:0] sent_ack_flags;
	logic [31:0] abort_ack_flags;
	logic [31:0] tx_config;
	logic [31:0] no_auto_retransmit;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;

	// ==========================================================
	// bus decode
	logic wr;
	logic wr_req;
	logic wr_can;
	logic wr_sent;
	logic wr_abort;
	logic wr_cfg;
	logic wr_noretx;
	logic wr_istat;
	logic wr_imask;
	logic [31:0] wdat;

	// write lands at the edge where the master samples ack
	assign wr = (state == can_tx_pkg::bus_ack) && cyc_i && stb_i && we_i;
	assign wdat = dat_i & byte_mask(sel_i);
	assign wr_req = wr && (adr_i == can_tx_pkg::ADDR_TX_REQUEST);
	assign wr_can = wr && (adr_i == can_tx_pkg::ADDR_TX_CANCEL);
	assign wr_sent = wr && (adr_i == can_tx_pkg::ADDR_SENT_ACK);
	assign wr_abort = wr && (adr_i == can_tx_pkg::ADDR_ABORT_ACK);
	assign wr_cfg = wr && (adr_i == can_tx_pkg::ADDR_TX_CONFIG);
	assign wr_noretx = wr && (adr_i == can_tx_pkg::ADDR_NO_RETX);
	assign wr_istat = wr && (adr_i == can_tx_pkg::ADDR_IRQ_STATUS);
	assign wr_imask = wr && (adr_i == can_tx_pkg::ADDR_IRQ_MASK);

	// ==========================================================
	// mailbox events
	logic [31:0] start_v;
	logic [31:0] done_v;
	logic [31:0] fail_v;
	logic [31:0] drop_v;
	logic [31:0] abort_v;
	logic [31:0] req_set;
	logic [31:0] can_set;
	logic [31:0] req_clr;
	logic [31:0] next_request;
	logic [31:0] next_cancel;
	logic [31:0] next_in_flight;

	assign start_v = one_hot(start_i);
	assign done_v = one_hot(done_i);
	assign fail_v = one_hot(fail_i);
	// failed try ends only without retry
	assign drop_v = fail_v & no_auto_retransmit;
	assign abort_v = tx_cancel & tx_request & ~in_flight;
	assign req_set = wr_req ? (wdat & tx_config & can_tx_pkg::MBOX_VALID_MASK) : can_tx_pkg::REG_RESET;
	assign can_set = wr_can ? (wdat & tx_config & can_tx_pkg::MBOX_VALID_MASK) : can_tx_pkg::REG_RESET;
	assign req_clr = done_v | drop_v | abort_v;
	assign next_request = ((tx_request & ~req_clr) | req_set) & can_tx_pkg::MBOX_VALID_MASK;
	assign next_cancel = (tx_cancel | can_set) & tx_request & ~req_clr;
	assign next_in_flight = (in_flight | start_v) & ~(done_v | fail_v) & can_tx_pkg::MBOX_VALID_MASK;

	// ==========================================================
	// wishbone handshake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= can_tx_pkg::bus_idle;
			ack_o <= 1'b0;
		end else if (ce_i) begin
			case (state)
				can_tx_pkg::bus_idle: begin
					if (cyc_i && stb_i) begin
						state <= can_tx_pkg::bus_ack;
						ack_o <= 1'b1;
					end
				end
				can_tx_pkg::bus_ack: begin
					state <= can_tx_pkg::bus_idle;
					ack_o <= 1'b0;
				end
				default: begin
					state <= can_tx_pkg::bus_idle;
					ack_o <= 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// read data, captured with ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= can_tx_pkg::REG_RESET;
		end else if (ce_i && state == can_tx_pkg::bus_idle && cyc_i && stb_i) begin
			case (adr_i)
				can_tx_pkg::ADDR_TX_REQUEST: dat_o <= tx_request;
				can_tx_pkg::ADDR_TX_CANCEL: dat_o <= tx_cancel;
				can_tx_pkg::ADDR_SENT_ACK: dat_o <= sent_ack_flags;
				can_tx_pkg::ADDR_ABORT_ACK: dat_o <= abort_ack_flags;
				can_tx_pkg::ADDR_TX_CONFIG: dat_o <= tx_config;
				can_tx_pkg::ADDR_NO_RETX: dat_o <= no_auto_retransmit;
				can_tx_pkg::ADDR_IRQ_STATUS: dat_o <= {29'h0000_0000, irq_status};
				can_tx_pkg::ADDR_IRQ_MASK: dat_o <= {29'h0000_0000, irq_mask};
				default: dat_o <= can_tx_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// ==========================================================
	// request, cancel, in-flight tracking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_request <= can_tx_pkg::REG_RESET;
			tx_cancel <= can_tx_pkg::REG_RESET;
			in_flight <= can_tx_pkg::REG_RESET;
		end else if (ce_i) begin
			tx_request <= next_request;
			tx_cancel <= next_cancel;
			in_flight <= next_in_flight;
		end
	end

	// ==========================================================
	// acknowledge flags, set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sent_ack_flags <= can_tx_pkg::REG_RESET;
			abort_ack_flags <= can_tx_pkg::REG_RESET;
		end else if (ce_i) begin
			sent_ack_flags <= ((sent_ack_flags & ~(wr_sent ? wdat : can_tx_pkg::REG_RESET)) | done_v)
				& can_tx_pkg::MBOX_VALID_MASK;
			abort_ack_flags <= ((abort_ack_flags & ~(wr_abort ? wdat : can_tx_pkg::REG_RESET)) | abort_v)
				& can_tx_pkg::MBOX_VALID_MASK;
		end
	end

	// ==========================================================
	// configuration
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_config <= can_tx_pkg::REG_RESET;
			no_auto_retransmit <= can_tx_pkg::REG_RESET;
		end else if (ce_i) begin
			if (wr_cfg)
				tx_config <= ((tx_config & ~byte_mask(sel_i)) | wdat) & can_tx_pkg::MBOX_VALID_MASK;
			if (wr_noretx)
				no_auto_retransmit <= ((no_auto_retransmit & ~byte_mask(sel_i)) | wdat)
					& can_tx_pkg::MBOX_VALID_MASK;
		end
	end

	// ==========================================================
	// interrupt status, mask, output
	logic [2:0] irq_set;

	assign irq_set = {|drop_v, |abort_v, |done_v};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status <= can_tx_pkg::IRQ_RESET;
			irq_mask <= can_tx_pkg::IRQ_RESET;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_status <= (irq_status & ~(wr_istat ? wdat[2:0] : can_tx_pkg::IRQ_RESET)) | irq_set;
			if (wr_imask)
				irq_mask <= (irq_mask & ~{3{sel_i[0]}}) | wdat[2:0];
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// ==========================================================
	// outputs to the frame engine
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_request_o <= can_tx_pkg::REG_RESET;
			tx_cancel_o <= can_tx_pkg::REG_RESET;
			no_auto_retransmit_o <= can_tx_pkg::REG_RESET;
		end else if (ce_i) begin
			tx_request_o <= next_request;
			tx_cancel_o <= next_cancel;
			no_auto_retransmit_o <= no_auto_retransmit;
		end
	end

	tx_mailbox_picker picker (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.eligible_i(tx_request & ~tx_cancel & ~in_flight),
		.valid_o(next_valid_o),
		.mbox_o(next_mbox_o)
	);

	// ==========================================================
	// checks
	sequence s_bus_req;
		ce_i && state == can_tx_pkg::bus_idle && cyc_i && stb_i;
	endsequence

	sequence s_ack_pulse;
		ack_o ##1 (!ack_o || !$past(ce_i));
	endsequence

	property p_bus_answer;
		@(posedge clk_i) disable iff (rst_i)
		s_bus_req |=> s_ack_pulse;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("ack not a one cycle answer");

	property p_bit0_zero;
		@(posedge clk_i) disable iff (rst_i)
		!tx_request[0] && !tx_cancel[0] && !tx_request_o[0];
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) else $error("bit 0 of request or cancel set");

	property p_set_pending;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_req) |=> ((tx_request & $past(req_set)) == $past(req_set));
	endproperty
	a_set_pending: assert property (p_set_pending) else $error("written request bit not pending");

	property p_only_tx_mbox;
		@(posedge clk_i) disable iff (rst_i)
		ce_i |=> ((tx_request & ~$past(tx_request) & ~$past(tx_config)) == can_tx_pkg::REG_RESET);
	endproperty
	a_only_tx_mbox: assert property (p_only_tx_mbox) else $error("request set on receive mailbox");

	property p_done_clears;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !wr_req && |done_v) |=> ((tx_request & $past(done_v)) == can_tx_pkg::REG_RESET);
	endproperty
	a_done_clears: assert property (p_done_clears) else $error("request kept after send");

	property p_retry;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |fail_v) |=> ((tx_request & $past(fail_v) & ~$past(no_auto_retransmit))
			== ($past(tx_request) & $past(fail_v) & ~$past(no_auto_retransmit)))
			&& ((tx_request & $past(drop_v) & ~$past(req_set)) == can_tx_pkg::REG_RESET);
	endproperty
	a_retry: assert property (p_retry) else $error("retry handling wrong after failure");

	property p_abort_done;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && !wr_req && |abort_v) |=> (((tx_request | tx_cancel) & $past(abort_v)) == can_tx_pkg::REG_RESET)
			&& ((abort_ack_flags & $past(abort_v)) == $past(abort_v));
	endproperty
	a_abort_done: assert property (p_abort_done) else $error("cancel did not complete");

	property p_in_flight_kept;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |(tx_cancel & in_flight) && !done_i.valid && !fail_i.valid)
			|=> ((tx_request & $past(in_flight)) == ($past(tx_request) & $past(in_flight)));
	endproperty
	a_in_flight_kept: assert property (p_in_flight_kept) else $error("started message was cancelled");

	property p_sent_flag;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |done_v) |=> ((sent_ack_flags & $past(done_v)) == $past(done_v)) ##1 1'b1;
	endproperty
	a_sent_flag: assert property (p_sent_flag) else $error("sent flag not set");

	property p_zero_write;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && wr_can && !(|req_clr)) |=> ((tx_request == $past(tx_request))
			&& ((tx_cancel & ~$past(tx_cancel) & ~$past(wdat)) == can_tx_pkg::REG_RESET));
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write changed a bit");

	property p_irq_level;
		@(posedge clk_i) disable iff (rst_i)
		(ce_i && |(irq_status & irq_mask)) |=> irq_o;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq low with unmasked status");

endmodule
`default_nettype wire

/* File: verification/frame_engine_model.sv */
// frame engine stand-in that raises start, done and fail events
`timescale 1ns/10ps
`default_nettype none
module frame_engine_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench command: 1 start, 2 sent, 3 failed attempt
	input wire logic [1:0] cmd_i,
	// choice of the block
	input wire logic next_valid_i,
	input wire logic [4:0] next_mbox_i,
	// events
	output var can_tx_pkg::tx_event_t start_o,
	output var can_tx_pkg::tx_event_t done_o,
	output var can_tx_pkg::tx_event_t fail_o,
	output logic busy_o
);
	logic [4:0] cur;

	// ==========================================
	// one mailbox on the bus at a time
	always_ff @(posedge clk_i) begin
		start_o <= {1'b0, ~start_o.mbox};
		done_o <= {1'b0, ~done_o.mbox};
		fail_o <= {1'b0, ~fail_o.mbox};
		if (rst_i) begin
			start_o <= '0;
			done_o <= '0;
			fail_o <= '0;
			busy_o <= 1'b0;
			cur <= 5'h00;
		end else if (cmd_i == 2'h1 && !busy_o && next_valid_i) begin
			start_o <= {1'b1, next_mbox_i};
			cur <= next_mbox_i;
			busy_o <= 1'b1;
		end else if (cmd_i[1] && busy_o) begin
			if (cmd_i[0]) begin
				fail_o <= {1'b1, cur};
			end else begin
				done_o <= {1'b1, cur};
			end
			busy_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the transmit request and cancel block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, irq_o, next_valid_o, busy;
	logic [3:0] sel_i;
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o, tx_request_o, tx_cancel_o, no_auto_retransmit_o, q;
	logic [4:0] next_mbox_o;
	logic [1:0] cmd;
	can_tx_pkg::tx_event_t start_ev, done_ev, fail_ev;
	int fail_count, checks_done;

	can_tx_request_cancel u_can_tx_request_cancel (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .start_i(start_ev), .done_i(done_ev), .fail_i(fail_ev),
		.tx_request_o(tx_request_o), .tx_cancel_o(tx_cancel_o), .no_auto_retransmit_o(no_auto_retransmit_o),
		.next_valid_o(next_valid_o), .next_mbox_o(next_mbox_o), .irq_o(irq_o));

	frame_engine_model u_frame_engine_model (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd),
		.next_valid_i(next_valid_o), .next_mbox_i(next_mbox_o), .start_o(start_ev), .done_o(done_ev),
		.fail_o(fail_ev), .busy_o(busy));

	// ==========================================
	// helpers
	task automatic finish_test;
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// classic single cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic [31:0] n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hf;
		n = 32'h0000_0000;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		// answer one cycle after the request is taken
		chk("ack wait", 32'h0000_0002, n);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		wb(1'b0, a, 32'h0000_0000);
		chk(name, exp, q);
	endtask

	task automatic eng(input logic [1:0] c);
		@(posedge clk_i);
		cmd <= c;
		@(posedge clk_i);
		cmd <= 2'h0;
		repeat (2) @(posedge clk_i);
	endtask

	// ==========================================
	// clock and watchdog
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		finish_test;
	end

	// ==========================================
	// tests
	initial begin
		fail_count = 0;
		checks_done = 0;
		rst_i = 1'b1;
		ce_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		sel_i = 4'h0;
		adr_i = 8'h00;
		dat_i = 32'h0000_0000;
		cmd = 2'h0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'h0000_0000, "request");
		rd(can_tx_pkg::ADDR_TX_CANCEL, 32'h0000_0000, "cancel");
		rd(8'h20, 32'h0000_0000, "unmapped");
		wb(1'b1, can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_ffff);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'h0000_0000, "request rx box");
		wb(1'b1, can_tx_pkg::ADDR_TX_CONFIG, 32'hffff_ffff);
		rd(can_tx_pkg::ADDR_TX_CONFIG, 32'hffff_fffe, "config");
		wb(1'b1, can_tx_pkg::ADDR_TX_CANCEL, 32'hffff_ffff);
		rd(can_tx_pkg::ADDR_TX_CANCEL, 32'h0000_0000, "cancel idle");
		wb(1'b1, can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_ffff);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fffe, "request set");
		chk("next mailbox", 32'h0000_0001, {27'h0, next_mbox_o});
		chk("next valid", 32'h0000_0001, {31'h0, next_valid_o});
		chk("request out", 32'hffff_fffe, tx_request_o);
		wb(1'b1, can_tx_pkg::ADDR_TX_REQUEST, 32'h0000_0000);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fffe, "request zero write");
		eng(2'h1);
		wb(1'b1, can_tx_pkg::ADDR_TX_CANCEL, 32'h0000_0002);
		rd(can_tx_pkg::ADDR_TX_CANCEL, 32'h0000_0002, "cancel in flight");
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fffe, "request in flight");
		chk("cancel out", 32'h0000_0002, tx_cancel_o);
		eng(2'h2);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fffc, "request after send");
		rd(can_tx_pkg::ADDR_SENT_ACK, 32'h0000_0002, "sent flags");
		rd(can_tx_pkg::ADDR_ABORT_ACK, 32'h0000_0000, "abort after send");
		wb(1'b1, can_tx_pkg::ADDR_TX_CANCEL, 32'h0000_0004);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fff8, "request after abort");
		rd(can_tx_pkg::ADDR_TX_CANCEL, 32'h0000_0000, "cancel after abort");
		rd(can_tx_pkg::ADDR_ABORT_ACK, 32'h0000_0004, "abort flags");
		eng(2'h1);
		eng(2'h3);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fff8, "request retry");
		wb(1'b1, can_tx_pkg::ADDR_NO_RETX, 32'h0000_0008);
		eng(2'h1);
		chk("no retry out", 32'h0000_0008, no_auto_retransmit_o);
		eng(2'h3);
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'hffff_fff0, "request no retry");
		rd(can_tx_pkg::ADDR_IRQ_STATUS, 32'h0000_0007, "irq status");
		chk("irq masked", 32'h0000_0000, {31'h0, irq_o});
		wb(1'b1, can_tx_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		chk("irq", 32'h0000_0001, {31'h0, irq_o});
		wb(1'b1, can_tx_pkg::ADDR_IRQ_STATUS, 32'h0000_0007);
		repeat (2) @(posedge clk_i);
		chk("irq cleared", 32'h0000_0000, {31'h0, irq_o});
		wb(1'b1, can_tx_pkg::ADDR_SENT_ACK, 32'h0000_0002);
		rd(can_tx_pkg::ADDR_SENT_ACK, 32'h0000_0000, "sent clear");
		// second reset in mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(can_tx_pkg::ADDR_TX_REQUEST, 32'h0000_0000, "request after reset");
		rd(can_tx_pkg::ADDR_TX_CONFIG, 32'h0000_0000, "config after reset");
		chk("next valid after reset", 32'h0000_0000, {31'h0, next_valid_o});
		finish_test;
	end
endmodule
`default_nettype wire
